// ### rtl/pnss_regs.svh
// Constants of the pipelined no-wait synchronous SRAM port.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef PNSS_REGS_SVH
`define PNSS_REGS_SVH
`define PNSS_AW 20
`define PNSS_DEPTH (1 << 20)
`define PNSS_LANES 4
`define PNSS_LW 9
`define PNSS_BW 8
`define PNSS_WW 36
`define PNSS_DW 32
`define PNSS_LSB_W 2
`define PNSS_STEP0 2'h0
`define PNSS_STEP1 2'h1
`define PNSS_ALL_MASK 4'hF
`define PNSS_X18_MASK 4'h3
`define PNSS_NO_LANES 4'h0
`define PNSS_SYNC_HI 2'h3
`define PNSS_SYNC_LO 2'h0
`endif

// ### rtl/pnss_pkg.sv
// Types of the pipelined no-wait synchronous SRAM port.
// Assumes pnss_regs.svh sits beside it.
`include "pnss_regs.svh"
package pnss_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_DESEL, ST_READ, ST_WRITE} pnss_state_t;
   // One pipeline slot: what the core does with one sampled edge
   typedef struct packed {
      logic rd;
      logic wr;
      logic [`PNSS_AW-1:0] addr;
      logic [`PNSS_LANES-1:0] lane_en;
   } pnss_cmd_t;
endpackage

// ### rtl/pnss_mem.sv
// Lane-wise storage array with a registered, write-first read port.
// Assumes enables are already qualified by the stall logic of the caller.
`timescale 1ns/1ps
`default_nettype none
`include "pnss_regs.svh"
module pnss_mem
(
   // Clock
   input wire logic clk_i,
   // Read port
   input wire logic re_i,
   input wire logic [`PNSS_AW-1:0] raddr_i,
   output logic [`PNSS_WW-1:0] rdata_o,
   // Write port
   input wire logic we_i,
   input wire logic [`PNSS_AW-1:0] waddr_i,
   input wire logic [`PNSS_LANES-1:0] wbe_i,
   input wire logic [`PNSS_WW-1:0] wdata_i
);
   ////////////////////////////////////////////////////////////////////////
   // One array per lane, so no word has two writers
   for (genvar l = 0; l < `PNSS_LANES; l++)
   begin : g_lane
      logic [`PNSS_LW-1:0] lane_mem [`PNSS_DEPTH];
      logic [`PNSS_LW-1:0] rd_q;
      logic hit;
      assign hit = we_i && wbe_i[l] && (waddr_i == raddr_i);
      // Byte-lane write
      always_ff @(posedge clk_i)
      begin
         if (we_i && wbe_i[l])
         begin
            lane_mem[waddr_i] <= wdata_i[l*`PNSS_LW +: `PNSS_LW];
         end
      end
      // Write-first read so a read right behind a write sees new data
      always_ff @(posedge clk_i)
      begin
         if (re_i)
         begin
            rd_q <= hit ? wdata_i[l*`PNSS_LW +: `PNSS_LW] : lane_mem[raddr_i];
         end
      end
      // Each lane owns its own read register, so no word has two writers
      assign rdata_o[l*`PNSS_LW +: `PNSS_LW] = rd_q;
   end
endmodule // pnss_mem
`default_nettype wire

// ### rtl/pnss_port.sv
// Synchronous port of a pipelined no-wait static RAM: control decode,
// burst counter, two-stage pipeline, data pin drive and sleep.
// Assumes the controls and data pins are synchronous to clk_i; the output
// enable, sleep and strap pins are not and pass two flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "pnss_regs.svh"
module pnss_port
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Synchronous controls
   input wire logic [`PNSS_AW-1:0] addr_i,
   input wire logic primary_select_n_i,
   input wire logic aux_select_high_i,
   input wire logic aux_select_low_i,
   input wire logic load_advance_i,
   input wire logic rw_select_i,
   input wire logic [`PNSS_LANES-1:0] byte_write_n_i,
   input wire logic clock_hold_n_i,
   // Asynchronous and strap inputs
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic burst_mode_i,
   input wire logic wide_org_i,
   // Data and parity pins
   input wire logic [`PNSS_DW-1:0] data_lanes_i,
   output logic [`PNSS_DW-1:0] data_lanes_o,
   output logic [`PNSS_DW-1:0] data_lanes_oe_o,
   input wire logic [`PNSS_LANES-1:0] parity_lanes_i,
   output logic [`PNSS_LANES-1:0] parity_lanes_o,
   output logic [`PNSS_LANES-1:0] parity_lanes_oe_o,
   // Status
   output logic sleep_active_o
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [1:0] oe_sync_q;
   logic [1:0] zz_sync_q;
   logic [1:0] mode_sync_q;
   logic [1:0] org_sync_q;
   logic oe_n;
   logic sleep;
   logic inter;
   logic go;
   logic sel;
   logic drive;
   logic [`PNSS_LANES-1:0] lanes_on;
   pnss_pkg::pnss_state_t state_q, state_d;
   logic [`PNSS_AW-1:0] base_q, base_d;
   logic [`PNSS_LSB_W-1:0] step_q, step_d;
   pnss_pkg::pnss_cmd_t s1_q, s1_d, s2_q;
   logic s3_rd_q;
   logic [`PNSS_WW-1:0] dout_q;
   logic [`PNSS_WW-1:0] mem_rdata;
   logic [`PNSS_WW-1:0] wdata;

   // Burst low bits for a step count in either order
   function automatic logic [`PNSS_LSB_W-1:0] burst_lsb(
      input logic [`PNSS_LSB_W-1:0] start,
      input logic [`PNSS_LSB_W-1:0] step,
      input logic interleaved);
      burst_lsb = interleaved ? (start ^ step) : start + step;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers; the pad pull-up on mode and pull-down on sleep set
   // the level an open pin presents, reset values match them
   // open pin defaults
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         oe_sync_q <= `PNSS_SYNC_HI;
         zz_sync_q <= `PNSS_SYNC_LO;
         mode_sync_q <= `PNSS_SYNC_HI;
         org_sync_q <= `PNSS_SYNC_HI;
      end
      else
      begin
         oe_sync_q <= {oe_sync_q[0], output_enable_n_i};
         zz_sync_q <= {zz_sync_q[0], sleep_request_i};
         mode_sync_q <= {mode_sync_q[0], burst_mode_i};
         org_sync_q <= {org_sync_q[0], wide_org_i};
      end
   end

   assign oe_n = oe_sync_q[1];
   assign sleep = zz_sync_q[1];
   assign inter = mode_sync_q[1];
   assign sleep_active_o = sleep;

   assign go = !clock_hold_n_i && !sleep;
   assign sel = !primary_select_n_i && aux_select_high_i && !aux_select_low_i;

   assign lanes_on = ~byte_write_n_i & (org_sync_q[1] ? `PNSS_ALL_MASK : `PNSS_X18_MASK);

   ////////////////////////////////////////////////////////////////////////
   // Cycle decode: what this edge asks for
   always_comb
   begin
      state_d = state_q;
      base_d = base_q;
      step_d = step_q;
      s1_d = '0;
      if (!load_advance_i)
      begin
         if (!sel)
         begin
            state_d = pnss_pkg::ST_DESEL;
         end
         else
         begin
            base_d = addr_i;
            step_d = `PNSS_STEP0;
            s1_d.addr = addr_i;
            s1_d.lane_en = lanes_on;
            if (rw_select_i)
            begin
               state_d = pnss_pkg::ST_READ;
               s1_d.rd = 1'b1;
            end
            else
            begin
               state_d = pnss_pkg::ST_WRITE;
               s1_d.wr = |lanes_on;
            end
         end
      end
      else
      begin
         case (state_q)
            pnss_pkg::ST_READ:
            begin
               step_d = step_q + `PNSS_STEP1;
               s1_d.rd = 1'b1;
            end
            pnss_pkg::ST_WRITE:
            begin
               step_d = step_q + `PNSS_STEP1;
               s1_d.wr = |lanes_on;
               s1_d.lane_en = lanes_on;
            end
            default:
            begin
               state_d = state_q;
            end
         endcase
         s1_d.addr = {base_q[`PNSS_AW-1:`PNSS_LSB_W], burst_lsb(base_q[`PNSS_LSB_W-1:0],
                      step_d, inter)};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Burst state; idle after reset so an early advance cannot continue
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= pnss_pkg::ST_IDLE;
         base_q <= '0;
         step_q <= `PNSS_STEP0;
      end
      else if (go)
      begin
         state_q <= state_d;
         base_q <= base_d;
         step_q <= step_d;
      end
   end

   // Pipeline; a held edge freezes every stage
   // two-edge read latency
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_rd_q <= 1'b0;
      end
      else if (go)
      begin
         s1_q <= s1_d;
         s2_q <= s1_q;
         s3_rd_q <= s2_q.rd;
      end
   end

   // Output data register, loaded from the array's read register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dout_q <= '0;
      end
      else if (go)
      begin
         dout_q <= mem_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lane packing: each lane is a parity bit over its data byte
   for (genvar l = 0; l < `PNSS_LANES; l++)
   begin : g_pack
      assign wdata[l*`PNSS_LW +: `PNSS_LW] = {parity_lanes_i[l],
                                              data_lanes_i[l*`PNSS_BW +: `PNSS_BW]};
      assign data_lanes_o[l*`PNSS_BW +: `PNSS_BW] = dout_q[l*`PNSS_LW +: `PNSS_BW];
      assign parity_lanes_o[l] = dout_q[l*`PNSS_LW + `PNSS_BW];
   end

   // Write data are taken at the second edge after the address
   // write data timing
   pnss_mem u_mem
   (
      .clk_i(clk_i),
      .re_i(go && s1_q.rd),
      .raddr_i(s1_q.addr),
      .rdata_o(mem_rdata),
      .we_i(go && s2_q.wr),
      .waddr_i(s2_q.addr),
      .wbe_i(s2_q.lane_en),
      .wdata_i(wdata)
   );

   // Pin drive; the master must still turn off drive before write data
   // dummy read floats
   assign drive = s3_rd_q && !oe_n && !sleep && !rst_i;
   assign data_lanes_oe_o = {`PNSS_DW{drive}};
   assign parity_lanes_oe_o = {`PNSS_LANES{drive}};

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_desel;
      go && !load_advance_i && !sel |=> state_q == pnss_pkg::ST_DESEL;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect not entered");
   property p_cont_desel;
      go && load_advance_i && (state_q == pnss_pkg::ST_DESEL) |=> state_q == pnss_pkg::ST_DESEL;
   endproperty
   a_cont_desel: assert property (p_cont_desel) else $error("left deselect");
   property p_rd_load;
      go && !load_advance_i && sel && rw_select_i |=> s1_q.rd && s1_q.addr == $past(addr_i);
   endproperty
   a_rd_load: assert property (p_rd_load) else $error("read load wrong");
   property p_rd_adv;
      go && load_advance_i && state_q == pnss_pkg::ST_READ
         |=> s1_q.rd && step_q == 2'($past(step_q) + `PNSS_STEP1);
   endproperty
   a_rd_adv: assert property (p_rd_adv) else $error("read advance wrong");
   property p_abort;
      go && !load_advance_i && sel && !rw_select_i && lanes_on == `PNSS_NO_LANES
         |=> !s1_q.wr ##1 !s2_q.wr;
   endproperty
   a_abort: assert property (p_abort) else $error("aborted write reached array");
   property p_hold;
      !go |=> $stable(state_q) && $stable(step_q) && $stable(s1_q) && $stable(dout_q);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved on a held edge");
   property p_no_drive;
      go && !s2_q.rd |=> !(|data_lanes_oe_o) && !(|parity_lanes_oe_o);
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("pins driven outside a read");
   property p_latency;
      go && s1_q.rd ##1 go |=> s3_rd_q;
   endproperty
   a_latency: assert property (p_latency) else $error("read data late");
   property p_sleep_in;
      $rose(sleep_request_i) ##1 sleep_request_i |=> !go && !(|parity_lanes_oe_o);
   endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("sampling after sleep");
   property p_inter;
      go && load_advance_i && state_q == pnss_pkg::ST_READ && inter
         |=> s1_q.addr[1:0] == (base_q[1:0] ^ step_q);
   endproperty
   a_inter: assert property (p_inter) else $error("interleave order wrong");

   c_rd_burst: cover property (go && s1_q.rd && state_q == pnss_pkg::ST_READ ##1 drive);
   c_wr_burst: cover property (go && s2_q.wr && s2_q.lane_en == `PNSS_ALL_MASK);
   c_sleep: cover property ($rose(sleep));
   c_hold: cover property (!clock_hold_n_i && s1_q.rd ##1 clock_hold_n_i);
endmodule // pnss_port
`default_nettype wire

// ### tb/pnss_master_model.sv
// Bus master model facing the SRAM port: write data on the pins.
// Assumes en_i marks exactly the edges that the port samples.
`timescale 1ns/1ps
`default_nettype none
module pnss_master_model
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Command as seen on the bus
   input wire logic en_i,
   input wire logic load_i,
   input wire logic sel_i,
   input wire logic rd_i,
   input wire logic [35:0] wd_i,
   input wire logic dev_oe_i,
   // Data pins toward the port
   output logic [31:0] data_o,
   output logic [3:0] parity_o,
   output logic clash_o
);
   logic wb_q;
   logic v1_q;
   logic v2_q;
   logic [35:0] d1_q;
   logic [35:0] d2_q;
   logic wr;
   ////////////////////////////////////////////////////////////////////////
   // A write burst goes on over advance edges until the next load
   assign wr = load_i ? (sel_i & ~rd_i) : wb_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_q <= 1'b0;
         v1_q <= 1'b0;
         v2_q <= 1'b0;
      end
      else if (en_i)
      begin
         wb_q <= wr;
         v1_q <= wr;
         v2_q <= v1_q;
         d1_q <= wd_i;
         d2_q <= d1_q;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         clash_o <= 1'b0;
      else if (v2_q && dev_oe_i)
         clash_o <= 1'b1;
   end
   // Released bus shows the inverse, so stale data never matches
   assign {parity_o, data_o} = v2_q ? d2_q : ~d2_q;
endmodule // pnss_master_model
`default_nettype wire

// ### tb/test_pipelined_nowait_sync_sram_port.sv
// Bench of the SRAM port: table of writes and read-backs, then bursts,
// deselects, clock hold, dummy read and sleep.
// Assumes the master model supplies write data two enabled edges late.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("ERROR %s expected %h seen %h", nm, e, g); \
      end \
   end
module test_pipelined_nowait_sync_sram_port;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [19:0] addr_i = 20'h0;
   logic psel_n = 1'b1;
   logic aux_hi = 1'b1;
   logic aux_lo = 1'b0;
   logic ld_adv = 1'b0;
   logic rw = 1'b0;
   logic [3:0] bw_n = 4'hF;
   logic hold_n = 1'b0;
   logic oe_n = 1'b0;
   logic sleep = 1'b0;
   logic mode = 1'b1;
   logic wide = 1'b1;
   logic [35:0] wd = 36'h0;
   logic [31:0] dq_i;
   logic [31:0] dq_o;
   logic [31:0] dq_oe;
   logic [3:0] par_i;
   logic [3:0] par_o;
   logic [3:0] par_oe;
   logic asleep;
   logic clash;
   int errors = 0;
   int n_compared = 0;
   // Rows: organisation, active-low lane write strobes, write word, word read back
   localparam logic [76:0] ROWS [8] = '{
      {1'b1, 4'h0, 36'h9_1122_3344, 36'h9_1122_3344},
      {1'b1, 4'hE, 36'hA_AAAA_AAAA, 36'h8_1122_33AA},
      {1'b1, 4'hF, 36'h0_0000_0000, 36'h8_1122_33AA},
      {1'b1, 4'h7, 36'h5_5500_0000, 36'h0_5522_33AA},
      {1'b1, 4'hD, 36'h0_0000_0000, 36'h0_5522_00AA},
      {1'b1, 4'hB, 36'hF_FFFF_FFFF, 36'h4_55FF_00AA},
      {1'b0, 4'h0, 36'hF_FFFF_FFFF, 36'h7_55FF_FFFF},
      {1'b0, 4'hD, 36'h0_0000_0000, 36'h5_55FF_00FF}};
   ////////////////////////////////////////////////////////////////////////
   pnss_port dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .primary_select_n_i(psel_n), .aux_select_high_i(aux_hi),
      .aux_select_low_i(aux_lo), .load_advance_i(ld_adv),
      .rw_select_i(rw), .byte_write_n_i(bw_n), .clock_hold_n_i(hold_n),
      .output_enable_n_i(oe_n), .sleep_request_i(sleep),
      .burst_mode_i(mode), .wide_org_i(wide),
      .data_lanes_i(dq_i), .data_lanes_o(dq_o), .data_lanes_oe_o(dq_oe),
      .parity_lanes_i(par_i), .parity_lanes_o(par_o),
      .parity_lanes_oe_o(par_oe), .sleep_active_o(asleep)
   );
   pnss_master_model master
   (
      .clk_i(clk_i), .rst_i(rst_i), .en_i(~hold_n & ~asleep),
      .load_i(~ld_adv), .sel_i(~psel_n & aux_hi & ~aux_lo), .rd_i(rw),
      .wd_i(wd), .dev_oe_i(dq_oe[0]), .data_o(dq_i), .parity_o(par_i),
      .clash_o(clash)
   );
   ////////////////////////////////////////////////////////////////////////
   // Clock, 5 ns period
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Kind 0 deselect, 1 read load, 2 write load, 3 advance (selects off)
   task automatic op(input int k, input logic [19:0] a, input logic [3:0] b,
                     input logic [35:0] d);
      addr_i = a;
      ld_adv = (k == 3);
      psel_n = (k == 0) || (k == 3);
      rw = (k == 1);
      bw_n = b;
      wd = d;
      @(posedge clk_i);
      #1;
   endtask
   task automatic idle(input int n);
      repeat (n) op(0, 20'h0, 4'hF, 36'h0);
   endtask
   // Drive check; data only looked at while driven
   task automatic chk(input logic on, input logic [35:0] ex);
      if (on)
         `CHK("read data", ex, {par_o, dq_o})
      `CHK("drive enable", {36{on}}, {par_oe, dq_oe})
   endtask
   // Hang guard, far beyond the roughly 120 cycles needed
   initial
   begin
      #20000;
      errors++;
      $display("ERROR watchdog expired");
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      int i;
      int m;
      int e;
      logic o;
      logic [3:0] b;
      logic [35:0] d;
      logic [35:0] ex;
      repeat (6) @(posedge clk_i);
      #1;
      chk(1'b0, 36'h0);
      rst_i = 1'b0;
      idle(1);
      chk(1'b0, 36'h0);
      // Write then read back to back, no turnaround gap
      for (i = 0; i < 8; i++)
      begin
         {o, b, d, ex} = ROWS[i];
         wide = o;
         idle(3);
         op(2, 20'h00010, b, d);
         op(1, 20'h00010, 4'hF, 36'h0);
         idle(2);
         chk(1'b1, ex);
      end
      wide = 1'b1;
      idle(3);
      op(2, 20'h00020, 4'h0, 36'hA00);
      for (i = 1; i < 4; i++)
         op(3, 20'h0, 4'h0, 36'hA00 + i);
      for (m = 0; m < 2; m++)
      begin
         mode = (m == 0);
         idle(3);
         for (i = 0; i < 6; i++)
         begin
            op(i == 0 ? 1 : (i < 4 ? 3 : 0), 20'(20'h00021 + 2 * m), 4'hF, 36'h0);
            e = (m == 0) ? ((1 ^ (i - 2)) & 3) : ((3 + i - 2) & 3);
            if (i >= 2)
               chk(1'b1, 36'hA00 + e);
         end
      end
      for (i = 0; i < 3; i++)
      begin
         aux_hi = (i != 1);
         aux_lo = (i == 2);
         op(i == 0 ? 0 : 1, 20'h00020, 4'hF, 36'h0);
         op(3, 20'h0, 4'hF, 36'h0);
         idle(1);
         chk(1'b0, 36'h0);
         idle(1);
         chk(1'b0, 36'h0);
      end
      aux_hi = 1'b1;
      aux_lo = 1'b0;
      op(1, 20'h00022, 4'hF, 36'h0);
      hold_n = 1'b1;
      op(1, 20'h00020, 4'hF, 36'h0);
      hold_n = 1'b0;
      idle(1);
      chk(1'b0, 36'h0);
      idle(1);
      chk(1'b1, 36'hA02);
      oe_n = 1'b1;
      idle(2);
      op(1, 20'h00021, 4'hF, 36'h0);
      idle(2);
      chk(1'b0, 36'h0);
      `CHK("dummy read data", 36'hA01, {par_o, dq_o})
      oe_n = 1'b0;
      idle(3);
      op(1, 20'h00023, 4'hF, 36'h0);
      idle(2);
      chk(1'b1, 36'hA03);
      hold_n = 1'b1;
      sleep = 1'b1;
      idle(3);
      `CHK("sleep state", 1'b1, asleep)
      chk(1'b0, 36'h0);
      sleep = 1'b0;
      idle(3);
      `CHK("sleep state", 1'b0, asleep)
      chk(1'b1, 36'hA03);
      hold_n = 1'b0;
      `CHK("bus clash", 1'b0, clash)
      print_verdict();
   end
endmodule // test_pipelined_nowait_sync_sram_port
`default_nettype wire
